// ===== sxi_pkg.sv
package sxi_pkg;

    // register byte offsets
    localparam logic [7:0] CORE_CTRL_OFFSET  = 8'h00;
    localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h04;
    localparam logic [7:0] FLAGS_OFFSET      = 8'h08;
    localparam logic [7:0] CPU_CTRL_OFFSET   = 8'h0c;
    localparam logic [7:0] STATE_OFFSET      = 8'h10;
    localparam logic [7:0] EVT_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] EVT_CLEAR_OFFSET  = 8'h18;
    localparam logic [7:0] EVT_ENABLE_OFFSET = 8'h1c;

    // core control register fields
    localparam int SENSE_LO_BIT   = 0;
    localparam int SENSE_HI_BIT   = 1;
    localparam int SLEEP_MODE_BIT = 4;
    localparam int SLEEP_EN_BIT   = 5;
    localparam logic [7:0] CORE_CTRL_WMASK = 8'h33;
    localparam logic [7:0] CORE_CTRL_RESET = 8'h00;

    // general irq mask, status flags and cpu control fields
    localparam int EXT_IRQ_MASK_BIT = 6;
    localparam int GLOBAL_IE_BIT    = 7;
    localparam int WDT_EN_BIT       = 0;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] CPU_CTRL_RESET = 8'h00;

    // event status bits
    localparam int EVT_EXT_IRQ = 0;
    localparam int EVT_SLEPT   = 1;
    localparam int EVT_WOKE    = 2;
    localparam int EVT_RESET   = 3;
    localparam logic [3:0] EVT_RESET_VAL = 4'h0;

    // reset delay time-out: 16K watchdog oscillator cycles
    localparam int RESET_DELAY_WDT_CYCLES = 16384;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_DECERR = 2'b11;

    typedef enum logic [1:0] {
        SENSE_LOW     = 2'b00,
        SENSE_RESERVE = 2'b01,
        SENSE_FALL    = 2'b10,
        SENSE_RISE    = 2'b11
    } sxi_sense_type;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_IDLE   = 2'b01,
        PWR_DOWN   = 2'b10,
        PWR_DELAY  = 2'b11
    } sxi_pwr_type;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } sxi_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sxi_axi_rsp_type;

endpackage : sxi_pkg

// ===== sleep_and_ext_irq_sense.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Function
// - mode bit: zero idle, one power-down
// - reserved bits three, two read zero
// - pin irq needs global and mask
// - sense: low, reserved, falling, rising
// - sample pin first; wider pulses caught
// - low level keeps request asserted
// - sleep only with enable bit set
// - irq wakes, routine, resume after sleep
// - sleep leaves registers unchanged
// - reset during sleep restarts at vector
// - idle halts cpu only, all wake
// - idle wake resumes with no delay
// - power-down stops oscillator, irq/watchdog run
// - power-down woken by reset, watchdog, level
// - level wake needs low past time-out
// - time-out is 16K watchdog cycles
// - enable bit at position five
module sleep_and_ext_irq_sense
    import sxi_pkg::*;
#(
    parameter int RESET_DELAY_CYCLES = RESET_DELAY_WDT_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire sxi_axi_req_type   axiReq,
    output sxi_axi_rsp_type        axiRsp,
    input  wire logic              extIrqPin,
    input  wire logic              sleepInstr,
    input  wire logic              instrDone,
    input  wire logic              irqAck,
    input  wire logic              wdtOscTick,
    input  wire logic              extResetReq,
    input  wire logic              wdtResetReq,
    input  wire logic              timerIrq,
    output logic                   extIrqReq,
    output logic                   cpuHalt,
    output logic                   oscStop,
    output logic                   resetVectorStart,
    output logic                   irqOut
);

    typedef struct packed {
        logic [7:0]      coreCtrl;
        logic [7:0]      irqMask;
        logic [7:0]      flags;
        logic [7:0]      cpuCtrl;
        logic [3:0]      evtStatus;
        logic [3:0]      evtEnable;
        logic            pinSync1;
        logic            pinSync2;
        logic            pinPrev;
        logic            edgePend;
        sxi_pwr_type     pwr;
        logic [15:0]     delayCnt;
        logic            vectorStart;
        logic            awTaken;
        logic [7:0]      awAddr;
        logic            wTaken;
        logic [31:0]     wData;
        logic [3:0]      wStrb;
        logic            bValid;
        logic [1:0]      bResp;
        logic            rValid;
        logic [31:0]     rData;
        logic [1:0]      rResp;
    } sxi_state_type;

    sxi_state_type state_reg;
    sxi_state_type state_next;

    function automatic logic addrKnown(input logic [7:0] a);
        addrKnown = (a == CORE_CTRL_OFFSET) || (a == IRQ_MASK_OFFSET)
                 || (a == FLAGS_OFFSET) || (a == CPU_CTRL_OFFSET)
                 || (a == STATE_OFFSET) || (a == EVT_STATUS_OFFSET)
                 || (a == EVT_CLEAR_OFFSET) || (a == EVT_ENABLE_OFFSET);
    endfunction : addrKnown

    function automatic logic [7:0] byteMerge(input logic [7:0] old,
                                             input logic [7:0] wd,
                                             input logic       en,
                                             input logic [7:0] wmask);
        byteMerge = en ? ((old & ~wmask) | (wd & wmask)) : old;
    endfunction : byteMerge

    sxi_sense_type sense;
    logic          irqEnabled;
    logic          levelActive;
    logic          edgeSeen;
    logic          wrFire;
    logic          rdFire;
    logic [3:0]    evtSet;
    logic [3:0]    evtClr;
    logic          wakeIrq;
    logic          anyReset;

    assign sense      = sxi_sense_type'({state_reg.coreCtrl[SENSE_HI_BIT],
                                         state_reg.coreCtrl[SENSE_LO_BIT]});
    assign irqEnabled = state_reg.flags[GLOBAL_IE_BIT]
                        && state_reg.irqMask[EXT_IRQ_MASK_BIT];
    assign levelActive = (sense == SENSE_LOW) && !state_reg.pinSync2;
    assign anyReset   = extResetReq || (wdtResetReq && state_reg.cpuCtrl[WDT_EN_BIT]);

    always_comb begin
        edgeSeen = 1'b0;
        unique case (sense)
            SENSE_FALL:    edgeSeen = state_reg.pinPrev && !state_reg.pinSync2;
            SENSE_RISE:    edgeSeen = !state_reg.pinPrev && state_reg.pinSync2;
            SENSE_LOW:     edgeSeen = 1'b0;
            SENSE_RESERVE: edgeSeen = 1'b0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        evtSet     = 4'h0;
        evtClr     = 4'h0;
        wakeIrq    = 1'b0;

        // pin synchroniser, first stage read only by second
        state_next.pinSync1 = extIrqPin;
        state_next.pinSync2 = state_reg.pinSync1;
        state_next.pinPrev  = state_reg.pinSync2;

        // edge latch cleared by vector fetch; set wins
        if (irqAck) begin
            state_next.edgePend = 1'b0;
        end
        if (edgeSeen) begin
            state_next.edgePend = 1'b1;
        end
        if (edgeSeen || levelActive) begin
            evtSet[EVT_EXT_IRQ] = 1'b1;
        end

        state_next.vectorStart = 1'b0;
        unique case (state_reg.pwr)
            PWR_ACTIVE: begin
                if (sleepInstr && state_reg.coreCtrl[SLEEP_EN_BIT]) begin
                    state_next.pwr = state_reg.coreCtrl[SLEEP_MODE_BIT]
                                     ? PWR_DOWN : PWR_IDLE;
                    evtSet[EVT_SLEPT] = 1'b1;
                end
            end
            PWR_IDLE: begin
                // any enabled irq wakes at once, cpu resumes next cycle
                wakeIrq = (irqEnabled && (state_reg.edgePend || levelActive))
                          || timerIrq;
                if (wakeIrq) begin
                    state_next.pwr = PWR_ACTIVE;
                    evtSet[EVT_WOKE] = 1'b1;
                end
            end
            PWR_DOWN: begin
                // edges ignored; only a held low level starts the delay
                if (irqEnabled && levelActive) begin
                    state_next.pwr      = PWR_DELAY;
                    state_next.delayCnt = 16'h0000;
                end
            end
            PWR_DELAY: begin
                if (!(irqEnabled && levelActive)) begin
                    state_next.pwr = PWR_DOWN;
                end else if (wdtOscTick) begin
                    if (32'(state_reg.delayCnt) >= RESET_DELAY_CYCLES - 1) begin
                        state_next.pwr   = PWR_ACTIVE;
                        evtSet[EVT_WOKE] = 1'b1;
                    end else begin
                        state_next.delayCnt = state_reg.delayCnt + 16'h0001;
                    end
                end
            end
        endcase

        if (anyReset) begin
            state_next.pwr         = PWR_ACTIVE;
            state_next.vectorStart = 1'b1;
            evtSet[EVT_RESET]      = 1'b1;
        end

        // axi write channel
        if (axiReq.awvalid && !state_reg.awTaken && !state_reg.bValid) begin
            state_next.awTaken = 1'b1;
            state_next.awAddr  = axiReq.awaddr;
        end
        if (axiReq.wvalid && !state_reg.wTaken && !state_reg.bValid) begin
            state_next.wTaken = 1'b1;
            state_next.wData  = axiReq.wdata;
            state_next.wStrb  = axiReq.wstrb;
        end
        if (wrFire) begin
            state_next.awTaken = 1'b0;
            state_next.wTaken  = 1'b0;
            state_next.bValid  = 1'b1;
            state_next.bResp   = addrKnown(state_reg.awAddr) ? AXI_OKAY : AXI_DECERR;
            if (state_reg.wStrb[0]) begin
                unique case (state_reg.awAddr)
                    CORE_CTRL_OFFSET: state_next.coreCtrl = byteMerge(state_reg.coreCtrl,
                                          state_reg.wData[7:0], 1'b1,
                                          CORE_CTRL_WMASK);
                    IRQ_MASK_OFFSET:  state_next.irqMask = state_reg.wData[7:0];
                    FLAGS_OFFSET:     state_next.flags = state_reg.wData[7:0];
                    CPU_CTRL_OFFSET:  state_next.cpuCtrl = state_reg.wData[7:0];
                    EVT_CLEAR_OFFSET: evtClr = state_reg.wData[3:0];
                    EVT_ENABLE_OFFSET: state_next.evtEnable = state_reg.wData[3:0];
                    default: ;
                endcase
            end
        end
        if (state_reg.bValid && axiReq.bready) begin
            state_next.bValid = 1'b0;
        end

        // axi read channel
        if (rdFire) begin
            state_next.rValid = 1'b1;
            state_next.rResp  = addrKnown(axiReq.araddr) ? AXI_OKAY : AXI_DECERR;
            state_next.rData  = 32'h0;
            unique case (axiReq.araddr)
                CORE_CTRL_OFFSET:  state_next.rData[7:0] = state_reg.coreCtrl
                                                         & CORE_CTRL_WMASK;
                IRQ_MASK_OFFSET:   state_next.rData[7:0] = state_reg.irqMask;
                FLAGS_OFFSET:      state_next.rData[7:0] = state_reg.flags;
                CPU_CTRL_OFFSET:   state_next.rData[7:0] = state_reg.cpuCtrl;
                STATE_OFFSET:      state_next.rData[7:0] = {5'h00, state_reg.pinSync2,
                                                            state_reg.pwr};
                EVT_STATUS_OFFSET: state_next.rData[3:0] = state_reg.evtStatus;
                EVT_ENABLE_OFFSET: state_next.rData[3:0] = state_reg.evtEnable;
                default: ;
            endcase
        end
        if (state_reg.rValid && axiReq.rready) begin
            state_next.rValid = 1'b0;
        end

        // sticky status: set beats clear
        state_next.evtStatus = (state_reg.evtStatus & ~evtClr) | evtSet;

        if (!reset_n) begin
            state_next = '0;
            state_next.coreCtrl  = CORE_CTRL_RESET;
            state_next.irqMask   = IRQ_MASK_RESET;
            state_next.flags     = FLAGS_RESET;
            state_next.cpuCtrl   = CPU_CTRL_RESET;
            state_next.evtStatus = EVT_RESET_VAL;
            state_next.evtEnable = EVT_RESET_VAL;
            state_next.pinSync1  = 1'b1;
            state_next.pinSync2  = 1'b1;
            state_next.pinPrev   = 1'b1;
            state_next.pwr       = PWR_ACTIVE;
        end
    end

    assign wrFire = state_reg.awTaken && state_reg.wTaken && !state_reg.bValid;
    assign rdFire = axiReq.arvalid && !state_reg.rValid;

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    always_comb begin
        axiRsp         = '0;
        axiRsp.awready = !state_reg.awTaken && !state_reg.bValid;
        axiRsp.wready  = !state_reg.wTaken && !state_reg.bValid;
        axiRsp.bvalid  = state_reg.bValid;
        axiRsp.bresp   = state_reg.bResp;
        axiRsp.arready = !state_reg.rValid;
        axiRsp.rvalid  = state_reg.rValid;
        axiRsp.rdata   = state_reg.rData;
        axiRsp.rresp   = state_reg.rResp;
    end

    assign extIrqReq        = irqEnabled && (state_reg.edgePend || levelActive);
    assign cpuHalt          = (state_reg.pwr != PWR_ACTIVE);
    assign oscStop          = (state_reg.pwr == PWR_DOWN)
                              || (state_reg.pwr == PWR_DELAY);
    assign resetVectorStart = state_reg.vectorStart;
    assign irqOut           = |(state_reg.evtStatus & state_reg.evtEnable);

endmodule : sleep_and_ext_irq_sense

`default_nettype wire

// ===== sxi_sleep_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sxi_sleep_asserts
    import sxi_pkg::*;
(
    input wire logic            mclk,
    input wire logic            reset_n,
    input wire sxi_axi_req_type axiReq,
    input wire sxi_axi_rsp_type axiRsp,
    input wire logic            sleepInstr,
    input wire logic            extResetReq,
    input wire logic            wdtResetReq,
    input wire logic            timerIrq,
    input wire logic            extIrqReq,
    input wire logic            cpuHalt,
    input wire logic            oscStop,
    input wire logic            resetVectorStart
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_halt_osc: assert property (oscStop |-> cpuHalt)
        else $error("oscillator stopped while cpu runs");
    a_halt_cause: assert property ($rose(cpuHalt) |-> $past(sleepInstr) ||
        $past(sleepInstr, 2) || $past(extResetReq) || $past(extResetReq, 2) || $past(wdtResetReq))
        else $error("cpu halted without sleep or reset");
    a_idle_wake: assert property (cpuHalt && !oscStop && (timerIrq || extIrqReq) |=> !cpuHalt)
        else $error("idle wake delayed");
    a_vector_start: assert property ($rose(extResetReq) |=> resetVectorStart)
        else $error("no reset vector start");
    a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read answer late");
    a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=>
        axiRsp.bvalid && $stable(axiRsp.bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=>
        axiRsp.rvalid && $stable(axiRsp.rdata))
        else $error("read data dropped");
    a_write_block: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write taken during response");
endmodule : sxi_sleep_asserts

bind sleep_and_ext_irq_sense sxi_sleep_asserts u_chk (
    .mclk(mclk), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .sleepInstr(sleepInstr), .extResetReq(extResetReq), .wdtResetReq(wdtResetReq),
    .timerIrq(timerIrq), .extIrqReq(extIrqReq), .cpuHalt(cpuHalt), .oscStop(oscStop),
    .resetVectorStart(resetVectorStart));
`default_nettype wire

// ===== sxi_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module sxi_cpu_model
    import sxi_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic doSleep,
    input  wire logic pinLow,
    input  wire logic ackOn,
    input  wire logic extIrqReq,
    input  wire logic cpuHalt,
    output logic      sleepInstr,
    output logic      instrDone,
    output logic      irqAck,
    output logic      extIrqPin
);
    initial begin
        sleepInstr = 1'b0;
        instrDone = 1'b0;
        irqAck = 1'b0;
        extIrqPin = 1'b1;
    end
    always @(posedge mclk) begin
        if (!reset_n) begin
            sleepInstr <= 1'b0;
            irqAck <= 1'b0;
            extIrqPin <= 1'b1;
        end else begin
            instrDone <= !instrDone;
            sleepInstr <= doSleep && !cpuHalt;
            irqAck <= ackOn && extIrqReq && !cpuHalt && !irqAck;
            // low kept until the running instruction ends
            if (pinLow) begin
                extIrqPin <= 1'b0;
            end else if (instrDone) begin
                extIrqPin <= 1'b1;
            end
        end
    end
endmodule : sxi_cpu_model
`default_nettype wire

// ===== tb_sleep_and_ext_irq_sense.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sleep_and_ext_irq_sense
    import sxi_pkg::*;
;
    logic            mclk;
    logic            reset_n;
    sxi_axi_req_type req;
    sxi_axi_rsp_type rsp;
    logic            doSleep, pinLow, ackOn, extRst, wdtRst, timerIrq;
    logic            tick = 1'b0;
    logic            sleepInstr, instrDone, irqAck, pin, irqReq, halt, oscStop, vecStart, irqOut;
    logic [1:0]      tickDiv = 2'h0;
    int              errorCnt, cmpCount, cyc;

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // watchdog oscillator: one tick every four clocks
    always @(posedge mclk) begin
        tickDiv <= tickDiv + 2'h1;
        tick <= (tickDiv == 2'h3);
        cyc++;
        if (cyc == 5000) begin
            errorCnt++;
            results();
        end
    end

    sxi_cpu_model cpu (.mclk(mclk), .reset_n(reset_n), .doSleep(doSleep), .pinLow(pinLow),
        .ackOn(ackOn), .extIrqReq(irqReq), .cpuHalt(halt), .sleepInstr(sleepInstr),
        .instrDone(instrDone), .irqAck(irqAck), .extIrqPin(pin));
    sleep_and_ext_irq_sense #(.RESET_DELAY_CYCLES(4)) dut (.mclk(mclk), .reset_n(reset_n),
        .axiReq(req), .axiRsp(rsp), .extIrqPin(pin), .sleepInstr(sleepInstr),
        .instrDone(instrDone), .irqAck(irqAck), .wdtOscTick(tick), .extResetReq(extRst),
        .wdtResetReq(wdtRst), .timerIrq(timerIrq), .extIrqReq(irqReq), .cpuHalt(halt),
        .oscStop(oscStop), .resetVectorStart(vecStart), .irqOut(irqOut));

    task automatic results();
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic ck(input int n);
        repeat (n) @(posedge mclk);
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = AXI_OKAY);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        chk({30'h0, rsp.bresp}, {30'h0, er});
        req.bready <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er = AXI_OKAY);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(posedge mclk); while (!(req.arvalid && rsp.arready));
        req.arvalid <= 1'b0;
        do @(posedge mclk); while (!rsp.rvalid);
        chk(rsp.rdata, ev);
        chk({30'h0, rsp.rresp}, {30'h0, er});
        req.rready <= 1'b0;
        @(posedge mclk);
    endtask : rd
    task automatic slp();
        doSleep <= 1'b1;
        ck(1);
        doSleep <= 1'b0;
        ck(4);
    endtask : slp
    task automatic irqOn();
        wr(FLAGS_OFFSET, 32'h80);
        wr(IRQ_MASK_OFFSET, 32'h40);
    endtask : irqOn

    initial begin
        req = '0;
        {doSleep, pinLow, ackOn, extRst, wdtRst, timerIrq} = '0;
        {errorCnt, cmpCount, cyc} = '0;
        reset_n = 1'b0;
        ck(16);
        reset_n <= 1'b1;
        ck(1);
        rd(CORE_CTRL_OFFSET, 32'h0);
        wr(CORE_CTRL_OFFSET, 32'hff);
        rd(CORE_CTRL_OFFSET, 32'h33);
        rd(8'h40, 32'h0, AXI_DECERR);
        wr(8'h40, 32'h0, AXI_DECERR);
        irqOn();
        for (int s = 0; s < 4; s++) begin
            wr(CORE_CTRL_OFFSET, 32'(s));
            pinLow <= 1'b1;
            ck(8);
            chk(irqReq, 32'(s == 0 || s == 2));
            pinLow <= 1'b0;
            ck(8);
            chk(irqReq, 32'(s >= 2));
            ackOn <= 1'b1;
            ck(3);
            ackOn <= 1'b0;
            ck(1);
        end
        wr(IRQ_MASK_OFFSET, 32'h0);
        wr(CORE_CTRL_OFFSET, 32'h0);
        pinLow <= 1'b1;
        ck(8);
        chk(irqReq, 32'h0);
        wr(IRQ_MASK_OFFSET, 32'h40);
        chk(irqReq, 32'h1);
        wr(FLAGS_OFFSET, 32'h0);
        chk(irqReq, 32'h0);
        pinLow <= 1'b0;
        wr(FLAGS_OFFSET, 32'h80);
        ck(8);
        wr(EVT_CLEAR_OFFSET, 32'hf);
        wr(EVT_ENABLE_OFFSET, 32'h2);
        rd(EVT_STATUS_OFFSET, 32'h0);
        slp();
        chk(halt, 32'h0);
        wr(CORE_CTRL_OFFSET, 32'h20);
        slp();
        chk({halt, oscStop, irqOut}, 32'h5);
        timerIrq <= 1'b1;
        ck(2);
        chk(halt, 32'h0);
        timerIrq <= 1'b0;
        rd(EVT_STATUS_OFFSET, 32'h6);
        wr(EVT_ENABLE_OFFSET, 32'h0);
        ck(2);
        chk(irqOut, 32'h0);
        wr(EVT_ENABLE_OFFSET, 32'h2);
        ck(2);
        chk(irqOut, 32'h1);
        wr(EVT_CLEAR_OFFSET, 32'h6);
        ck(2);
        chk(irqOut, 32'h0);
        wr(CORE_CTRL_OFFSET, 32'h32);
        slp();
        chk(oscStop, 32'h1);
        pinLow <= 1'b1;
        ck(3);
        pinLow <= 1'b0;
        ck(10);
        chk(oscStop, 32'h1);
        extRst <= 1'b1;
        ck(1);
        extRst <= 1'b0;
        ck(1);
        chk(vecStart, 32'h1);
        ck(30);
        chk(halt, 32'h0);
        // watchdog reset ignored while disabled, honoured once enabled
        wr(IRQ_MASK_OFFSET, 32'h0);
        wr(CORE_CTRL_OFFSET, 32'h20);
        slp();
        wdtRst <= 1'b1;
        ck(1);
        wdtRst <= 1'b0;
        ck(2);
        chk(halt, 32'h1);
        rd(STATE_OFFSET, 32'h5);
        wr(CPU_CTRL_OFFSET, 32'h1);
        rd(CPU_CTRL_OFFSET, 32'h1);
        wdtRst <= 1'b1;
        ck(1);
        wdtRst <= 1'b0;
        ck(1);
        chk({halt, vecStart}, 32'h1);
        wr(CPU_CTRL_OFFSET, 32'h0);
        irqOn();
        wr(CORE_CTRL_OFFSET, 32'h30);
        slp();
        pinLow <= 1'b1;
        ck(8);
        pinLow <= 1'b0;
        ck(6);
        chk(oscStop, 32'h1);
        pinLow <= 1'b1;
        ck(40);
        pinLow <= 1'b0;
        ck(40);
        chk({halt, oscStop}, 32'h0);
        rd(CORE_CTRL_OFFSET, 32'h30);
        results();
    end
endmodule : tb_sleep_and_ext_irq_sense
`default_nettype wire
